// file: core/fpi_pkg.sv
// package for the front panel indicator logic: constants and carrier structs
package fpi_pkg;

  localparam int CLK_HZ = 40000000;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int IDLE_MS = 30000;
  localparam int IDLE_CYC = CLK_HZ / 1000 * IDLE_MS;
  localparam int DWELL_MS = 2000;
  localparam int DWELL_CYC = CLK_HZ / 1000 * DWELL_MS;
  localparam int MAX_DEFAULT_MSGS = 30;
  localparam int NUM_GROUPS = 4;
  localparam int NUM_COND = 8;
  localparam int NUM_AUX = 5;

  localparam logic [31:0] WB_ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] WB_ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] WB_ADDR_LAMPS = 32'h0000_0008;
  localparam logic [31:0] WB_ADDR_DIAG = 32'h0000_000c;

  // control register fields
  localparam int CTRL_LAMP_TEST = 0;
  localparam int CTRL_RESET_CMD = 1;
  localparam int CTRL_SINGLE_CONTACT = 2;
  localparam int CTRL_CONTACT_IS_OPEN_SENSE = 3;
  localparam int CTRL_NUM_DEFAULT_LSB = 8;
  localparam int CTRL_NUM_DEFAULT_W = 5;
  localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0100;

  typedef enum logic [1:0] {
    FPI_DISP_DEFAULT = 2'b00,
    FPI_DISP_DIAG = 2'b01,
    FPI_DISP_SCROLL = 2'b10
  } fpi_disp_type;

  typedef struct packed {
    logic in_service;
    logic self_test;
    logic trip;
    logic alarm;
    logic pickup;
    logic [3:0] group;
    logic brk_open;
    logic brk_closed;
    logic rcl_enabled;
    logic rcl_disabled;
    logic rcl_progress;
    logic rcl_lockout;
    logic local_mode;
    logic message;
  } fpi_lamps_type;

  typedef struct packed {
    logic open_cmd;
    logic close_cmd;
  } fpi_brk_cmd_type;

endpackage

// file: core/fpi_blink.sv
// shared blink timebase for all flashing lamps
`timescale 1ns/100ps
`default_nettype none
module fpi_blink #(
  parameter int HALF_CYC = fpi_pkg::BLINK_HALF_CYC
) (
  input wire logic clk,
  input wire logic reset,
  output logic phase
);
  typedef struct packed {
    logic [31:0] cnt;
    logic phase;
  } fpi_blink_st_type;

  fpi_blink_st_type st_r;
  fpi_blink_st_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (st_r.cnt >= 32'(HALF_CYC - 1)) begin
      st_nxt.cnt = 32'h0000_0000;
      st_nxt.phase = ~st_r.phase;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign phase = st_r.phase;
endmodule
`default_nettype wire

// file: core/fpi_core.sv
// front panel indicator logic with wishbone register slave
// Functional notes
// - in-service lamp lit when healthy
// - major failure: lamp off, outputs off, warning
// - trip lamp flashes on trip
// - trip lamp latched until reset after clear
// - unlatched alarm lamp flashes, self-clears
// - latched output relays hold until reset
// - latched alarm flashes, then steady until reset
// - pickup lamp follows pickup condition
// - group lamps flash edit, steady active
// - lamp test only without trip or alarm
// - two contacts give closed and open
// - both contacts open: both lamps off
// - single contact needs breaker connected input
// - reclose enabled lamp and its complement
// - in-progress lamp during dead times
// - lockout lamp held until reset
// - local lamp follows local input
// - local mode gates open/close sources
// - diagnostic overrides display, next steps
// - message lamp flashes while diagnostics active
// - unlatched alarm messages drop, latched alarm and trip messages held
// - idle scroll of default messages, overrides
`timescale 1ns/100ps
`default_nettype none
module fpi_core #(
  parameter int BLINK_HALF_CYC = fpi_pkg::BLINK_HALF_CYC,
  parameter int IDLE_CYC = fpi_pkg::IDLE_CYC,
  parameter int DWELL_CYC = fpi_pkg::DWELL_CYC,
  parameter int NUM_COND = fpi_pkg::NUM_COND
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic major_fail,
  input wire logic minor_fail,
  input wire logic trip_cond,
  input wire logic [NUM_COND-1:0] alarm_cond,
  input wire logic [NUM_COND-1:0] alarm_latched_cfg,
  input wire logic pickup_cond,
  input wire logic [fpi_pkg::NUM_AUX-1:0] aux_request,
  input wire logic [fpi_pkg::NUM_AUX-1:0] aux_latched_cfg,
  input wire logic [1:0] active_group,
  input wire logic [1:0] edit_group,
  input wire logic edit_active,
  input wire logic breaker_closed_sense_contact,
  input wire logic breaker_open_sense_contact,
  input wire logic breaker_connected_in,
  input wire logic rcl_function_on,
  input wire logic rcl_block_in,
  input wire logic rcl_dead_time,
  input wire logic rcl_final_lockout,
  input wire logic local_in,
  input wire logic reset_key,
  input wire logic next_key,
  input wire logic other_key,
  input wire logic open_key,
  input wire logic close_key,
  input wire fpi_pkg::fpi_brk_cmd_type remote_cmd,
  input wire fpi_pkg::fpi_brk_cmd_type comms_cmd,
  output fpi_pkg::fpi_lamps_type lamps,
  output fpi_pkg::fpi_brk_cmd_type brk_cmd,
  output logic trip_relay,
  output logic [fpi_pkg::NUM_AUX-1:0] aux_relay,
  output logic self_test_relay,
  output logic [1:0] disp_mode,
  output logic [4:0] disp_default_idx,
  output logic [3:0] disp_diag_idx
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic ack;
    logic [31:0] dat;
    logic trip_latch;
    logic [NUM_COND-1:0] alarm_latch;
    logic [fpi_pkg::NUM_AUX-1:0] aux_latch;
    logic lockout;
    logic [NUM_COND:0] diag_q;
    fpi_pkg::fpi_disp_type disp;
    fpi_pkg::fpi_disp_type pre_scroll;
    logic [3:0] diag_idx;
    logic [4:0] dflt_idx;
    logic [4:0] saved_idx;
    logic [31:0] idle_cnt;
    logic [31:0] dwell_cnt;
    logic prev_active;
    fpi_pkg::fpi_lamps_type lamps;
    fpi_pkg::fpi_brk_cmd_type cmd;
    logic trip_out;
    logic [fpi_pkg::NUM_AUX-1:0] aux_out;
    logic st_relay;
  } fpi_core_st_type;

  fpi_core_st_type st_r;
  fpi_core_st_type st_nxt;
  logic blink;
  logic healthy;
  logic any_alarm;
  logic any_trip_alarm;
  logic clr;
  logic lamp_test;
  logic any_key;
  logic wb_req;
  logic [NUM_COND:0] diag_now;
  logic [4:0] num_dflt;
  logic [fpi_pkg::NUM_AUX-1:0] aux_now;

  // single timebase so every flashing lamp toggles in phase
  fpi_blink #(
    .HALF_CYC(BLINK_HALF_CYC)
  ) u_blink (
    .clk(clk),
    .reset(reset),
    .phase(blink)
  );

  always_comb begin
    healthy = ~major_fail;
    any_alarm = |alarm_cond;
    clr = reset_key | st_r.ctrl[fpi_pkg::CTRL_RESET_CMD];
    any_trip_alarm = st_r.trip_latch | any_alarm | trip_cond;
    lamp_test = st_r.ctrl[fpi_pkg::CTRL_LAMP_TEST] & ~any_trip_alarm;
    any_key = next_key | other_key | open_key | close_key | reset_key;
    wb_req = wb_cyc_i & wb_stb_i & ~st_r.ack;
    diag_now = {st_r.trip_latch | trip_cond, alarm_cond | st_r.alarm_latch};
    num_dflt = st_r.ctrl[fpi_pkg::CTRL_NUM_DEFAULT_LSB +: fpi_pkg::CTRL_NUM_DEFAULT_W];
    if (num_dflt > 5'(fpi_pkg::MAX_DEFAULT_MSGS)) begin
      num_dflt = 5'(fpi_pkg::MAX_DEFAULT_MSGS);
    end
    aux_now = aux_request | st_r.aux_latch;
  end

  always_comb begin
    st_nxt = st_r;
    // wishbone slave, one wait state, write-one reset bit self-clears
    st_nxt.ack = wb_req;
    st_nxt.ctrl[fpi_pkg::CTRL_RESET_CMD] = 1'b0;
    if (wb_req && wb_we_i && wb_adr_i == fpi_pkg::WB_ADDR_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          st_nxt.ctrl[b*8 +: 8] = wb_dat_i[b*8 +: 8];
        end
      end
    end
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        fpi_pkg::WB_ADDR_CTRL: st_nxt.dat = st_r.ctrl;
        fpi_pkg::WB_ADDR_STATUS: st_nxt.dat = {24'h00_0000, st_r.diag_q[NUM_COND],
          st_r.lockout, 1'b0, st_r.disp, st_r.trip_out, st_r.st_relay, st_r.trip_latch};
        fpi_pkg::WB_ADDR_LAMPS: st_nxt.dat = 32'(st_r.lamps);
        fpi_pkg::WB_ADDR_DIAG: st_nxt.dat = 32'(st_r.diag_q);
        default: st_nxt.dat = 32'h0000_0000;
      endcase
    end

    // trip latch: set wins over reset, reset only after fault gone
    if (trip_cond) begin
      st_nxt.trip_latch = 1'b1;
    end else if (clr) begin
      st_nxt.trip_latch = 1'b0;
    end
    for (int i = 0; i < NUM_COND; i++) begin
      if (alarm_cond[i] && alarm_latched_cfg[i]) begin
        st_nxt.alarm_latch[i] = 1'b1;
      end else if (clr) begin
        st_nxt.alarm_latch[i] = 1'b0;
      end
    end
    for (int i = 0; i < fpi_pkg::NUM_AUX; i++) begin
      if (aux_request[i] && aux_latched_cfg[i]) begin
        st_nxt.aux_latch[i] = 1'b1;
      end else if (clr) begin
        st_nxt.aux_latch[i] = 1'b0;
      end
    end
    if (rcl_final_lockout) begin
      st_nxt.lockout = 1'b1;
    end else if (clr) begin
      st_nxt.lockout = 1'b0;
    end

    // alarm entries follow condition or alarm latch, trip entry held by its latch
    st_nxt.diag_q = diag_now;

    // relay outputs; a major failure drops them all
    st_nxt.trip_out = healthy & trip_cond;
    st_nxt.aux_out = healthy ? aux_now : '0;
    st_nxt.st_relay = ~(major_fail | minor_fail);

    // breaker commands: local accepts keys only, remote and comms otherwise
    st_nxt.cmd = '0;
    if (healthy) begin
      if (local_in) begin
        st_nxt.cmd.open_cmd = open_key;
        st_nxt.cmd.close_cmd = close_key;
      end else begin
        st_nxt.cmd = remote_cmd | comms_cmd;
      end
    end

    // display arbitration
    st_nxt.prev_active = |diag_now;
    if (any_key) begin
      st_nxt.idle_cnt = 32'h0000_0000;
    end else if (st_r.idle_cnt < 32'(IDLE_CYC)) begin
      st_nxt.idle_cnt = st_r.idle_cnt + 32'h0000_0001;
    end
    case (st_r.disp)
      fpi_pkg::FPI_DISP_DEFAULT: begin
        if (|diag_now && !st_r.prev_active) begin
          st_nxt.disp = fpi_pkg::FPI_DISP_DIAG;
          st_nxt.diag_idx = 4'h0;
        end else if (next_key && |diag_now) begin
          st_nxt.disp = fpi_pkg::FPI_DISP_DIAG;
          st_nxt.diag_idx = 4'h0;
        end else if (st_r.idle_cnt >= 32'(IDLE_CYC) && num_dflt != 5'h00) begin
          st_nxt.disp = fpi_pkg::FPI_DISP_SCROLL;
          st_nxt.pre_scroll = fpi_pkg::FPI_DISP_DEFAULT;
          st_nxt.saved_idx = st_r.dflt_idx;
          st_nxt.dwell_cnt = 32'h0000_0000;
        end
      end
      fpi_pkg::FPI_DISP_DIAG: begin
        if (!(|diag_now)) begin
          st_nxt.disp = fpi_pkg::FPI_DISP_DEFAULT;
        end else if (next_key) begin
          if (st_r.diag_idx >= 4'(NUM_COND)) begin
            st_nxt.diag_idx = 4'h0;
          end else begin
            st_nxt.diag_idx = st_r.diag_idx + 4'h1;
          end
        end else if (other_key) begin
          st_nxt.disp = fpi_pkg::FPI_DISP_DEFAULT;
        end
      end
      fpi_pkg::FPI_DISP_SCROLL: begin
        if (|diag_now && !st_r.prev_active) begin
          st_nxt.disp = fpi_pkg::FPI_DISP_DIAG;
          st_nxt.diag_idx = 4'h0;
        end else if (any_key) begin
          st_nxt.disp = st_r.pre_scroll;
          st_nxt.dflt_idx = st_r.saved_idx;
        end else if (st_r.dwell_cnt >= 32'(DWELL_CYC - 1)) begin
          st_nxt.dwell_cnt = 32'h0000_0000;
          st_nxt.dflt_idx = (st_r.dflt_idx + 5'h01 >= num_dflt) ? 5'h00
            : st_r.dflt_idx + 5'h01;
        end else begin
          st_nxt.dwell_cnt = st_r.dwell_cnt + 32'h0000_0001;
        end
      end
      default: st_nxt.disp = fpi_pkg::FPI_DISP_DEFAULT;
    endcase

    // lamps
    st_nxt.lamps.in_service = healthy;
    st_nxt.lamps.self_test = major_fail | minor_fail;
    st_nxt.lamps.trip = trip_cond ? blink : st_r.trip_latch;
    st_nxt.lamps.alarm = any_alarm ? blink : |st_r.alarm_latch;
    st_nxt.lamps.pickup = pickup_cond;
    for (int g = 0; g < fpi_pkg::NUM_GROUPS; g++) begin
      if (edit_active && edit_group == 2'(g)) begin
        st_nxt.lamps.group[g] = blink;
      end else begin
        st_nxt.lamps.group[g] = active_group == 2'(g);
      end
    end
    if (st_r.ctrl[fpi_pkg::CTRL_SINGLE_CONTACT]) begin
      // one contact cannot tell open from racked out
      if (!breaker_connected_in) begin
        st_nxt.lamps.brk_open = 1'b0;
        st_nxt.lamps.brk_closed = 1'b0;
      end else if (st_r.ctrl[fpi_pkg::CTRL_CONTACT_IS_OPEN_SENSE]) begin
        st_nxt.lamps.brk_open = breaker_open_sense_contact;
        st_nxt.lamps.brk_closed = ~breaker_open_sense_contact;
      end else begin
        st_nxt.lamps.brk_open = ~breaker_closed_sense_contact;
        st_nxt.lamps.brk_closed = breaker_closed_sense_contact;
      end
    end else begin
      st_nxt.lamps.brk_closed = breaker_closed_sense_contact;
      st_nxt.lamps.brk_open = breaker_open_sense_contact;
    end
    st_nxt.lamps.rcl_enabled = rcl_function_on & ~rcl_block_in;
    st_nxt.lamps.rcl_disabled = ~(rcl_function_on & ~rcl_block_in);
    st_nxt.lamps.rcl_progress = rcl_dead_time;
    st_nxt.lamps.rcl_lockout = rcl_final_lockout | st_r.lockout;
    st_nxt.lamps.local_mode = local_in;
    st_nxt.lamps.message = (|diag_now) & blink;
    if (lamp_test) begin
      st_nxt.lamps = '1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
      st_r.ctrl <= fpi_pkg::CTRL_RESET_VAL;
      st_r.st_relay <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.dat;
  assign lamps = st_r.lamps;
  assign brk_cmd = st_r.cmd;
  assign trip_relay = st_r.trip_out;
  assign aux_relay = st_r.aux_out;
  assign self_test_relay = st_r.st_relay;
  assign disp_mode = st_r.disp;
  assign disp_default_idx = st_r.dflt_idx;
  assign disp_diag_idx = st_r.diag_idx;

  // assertions
  a_fail_kills_out: assert property (@(posedge clk) disable iff (reset)
    major_fail |=> !trip_relay && aux_relay == '0 && !lamps.in_service)
    else $error("outputs live during major failure");
  a_trip_latch_hold: assert property (@(posedge clk) disable iff (reset)
    trip_cond ##1 (!trip_cond && !clr) |=> st_r.trip_latch)
    else $error("trip latch lost without reset");
  a_alarm_unlatched: assert property (@(posedge clk) disable iff (reset)
    (alarm_cond == '0 && st_r.alarm_latch == '0 && !lamp_test) |=> !lamps.alarm)
    else $error("alarm lamp on with no alarm");
  a_aux_latched: assert property (@(posedge clk) disable iff (reset)
    (aux_request[0] && aux_latched_cfg[0] && !major_fail) ##1 (!clr && !major_fail)
    |=> aux_relay[0])
    else $error("latched aux relay dropped");
  a_pickup_follow: assert property (@(posedge clk) disable iff (reset)
    (!lamp_test) |=> lamps.pickup == $past(pickup_cond))
    else $error("pickup lamp wrong");
  a_lamp_test_gate: assert property (@(posedge clk) disable iff (reset)
    (trip_cond || alarm_cond != '0) |=> !(lamps.rcl_enabled && lamps.rcl_disabled))
    else $error("lamp test during trip");
  a_rcl_compl: assert property (@(posedge clk) disable iff (reset)
    !lamp_test |=> lamps.rcl_enabled != lamps.rcl_disabled)
    else $error("reclose lamps not complementary");
  a_local_gate: assert property (@(posedge clk) disable iff (reset)
    (local_in && !open_key) |=> !brk_cmd.open_cmd)
    else $error("remote open accepted in local mode");
  a_msg_flash: assert property (@(posedge clk) disable iff (reset)
    (diag_now == '0 && !lamp_test) |=> !lamps.message)
    else $error("message lamp without diagnostics");
  a_ack_single: assert property (@(posedge clk) disable iff (reset)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule
`default_nettype wire

// file: verif/fpi_breaker_model.sv
// breaker with auxiliary contacts, driven by the relay's trip and command outputs
`timescale 1ns/100ps
`default_nettype none
module fpi_breaker_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic trip_relay,
  input wire fpi_pkg::fpi_brk_cmd_type brk_cmd,
  input wire logic racked_in,
  input wire logic open_wired,
  output logic closed_contact,
  output logic open_contact
);
  logic closed_r;
  // open wins over close, as a trip coil overrides a close coil
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      closed_r <= 1'b0;
    end else if (trip_relay || brk_cmd.open_cmd) begin
      closed_r <= 1'b0;
    end else if (brk_cmd.close_cmd) begin
      closed_r <= 1'b1;
    end
  end
  // a racked-out breaker leaves both contacts open
  assign closed_contact = racked_in & closed_r;
  assign open_contact = racked_in & open_wired & ~closed_r;
endmodule
`default_nettype wire

// file: verif/testbench.sv
// self-checking testbench for the front panel indicator logic
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int OFF = 0, ON = 1, FL = 2;
  localparam int L_INS = 16, L_STW = 15, L_TRP = 14, L_ALM = 13, L_PKP = 12, L_GRP = 8;
  localparam int L_BOP = 7, L_BCL = 6, L_REN = 5, L_RDI = 4, L_RIP = 3, L_RLO = 2;
  localparam int L_LOC = 1, L_MSG = 0;
  localparam logic [31:0] CTRL = fpi_pkg::WB_ADDR_CTRL;
  logic clk, reset, we, cyc, stb, ack;
  logic [31:0] adr, wdat, rdat, q;
  logic [3:0] sel, didx, d0;
  logic major_fail, minor_fail, trip_cond, pickup_cond, edit_active, conn;
  logic rcl_on, rcl_blk, rcl_dead, rcl_lock, local_in, racked_in, open_wired;
  logic bcc, boc, trip_relay, st_relay;
  logic [7:0] alarm_cond, alarm_lcfg;
  logic [4:0] aux_req, aux_lcfg, aux_relay, keys, sidx;
  logic [1:0] active_group, edit_group, disp_mode;
  fpi_pkg::fpi_brk_cmd_type remote_cmd, comms_cmd, brk_cmd;
  fpi_pkg::fpi_lamps_type lamps;
  logic [16:0] lv;
  int n_fail, compares, mx;
  assign lv = lamps;

  fpi_core #(.BLINK_HALF_CYC(4), .IDLE_CYC(20), .DWELL_CYC(5), .NUM_COND(8)) u_fpi_core (
    .clk(clk), .reset(reset), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .major_fail(major_fail), .minor_fail(minor_fail), .trip_cond(trip_cond),
    .alarm_cond(alarm_cond), .alarm_latched_cfg(alarm_lcfg), .pickup_cond(pickup_cond),
    .aux_request(aux_req), .aux_latched_cfg(aux_lcfg), .active_group(active_group),
    .edit_group(edit_group), .edit_active(edit_active),
    .breaker_closed_sense_contact(bcc), .breaker_open_sense_contact(boc),
    .breaker_connected_in(conn), .rcl_function_on(rcl_on), .rcl_block_in(rcl_blk),
    .rcl_dead_time(rcl_dead), .rcl_final_lockout(rcl_lock), .local_in(local_in),
    .reset_key(keys[0]), .next_key(keys[1]), .other_key(keys[2]), .open_key(keys[3]),
    .close_key(keys[4]), .remote_cmd(remote_cmd), .comms_cmd(comms_cmd), .lamps(lamps),
    .brk_cmd(brk_cmd), .trip_relay(trip_relay), .aux_relay(aux_relay),
    .self_test_relay(st_relay), .disp_mode(disp_mode), .disp_default_idx(sidx),
    .disp_diag_idx(didx));

  fpi_breaker_model u_fpi_breaker_model (
    .clk(clk), .reset(reset), .trip_relay(trip_relay), .brk_cmd(brk_cmd),
    .racked_in(racked_in), .open_wired(open_wired), .closed_contact(bcc),
    .open_contact(boc));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task results;
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // off, steady or flashing, judged over more than one blink period
  task lamp_chk(input int idx, input int mode);
    int ones, zeros;
    ones = 0;
    zeros = 0;
    repeat (3) @(posedge clk);
    repeat (12) begin
      @(posedge clk);
      if (lv[idx] === 1'b1) ones++;
      if (lv[idx] === 1'b0) zeros++;
    end
    compares++;
    if (ones + zeros != 12 || (mode == OFF && ones != 0) || (mode == ON && zeros != 0)
        || (mode == FL && (ones == 0 || zeros == 0))) begin
      n_fail++;
      $display("unexpected lamp at %0t: bit %0d mode %0d ones %0d", $time, idx, mode, ones);
    end
  endtask

  // classic single cycle, held until ack is sampled high
  task wb(input logic [31:0] a, input logic [31:0] d, input logic w);
    int t;
    t = 0;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    we <= w;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (t >= 40) begin
      n_fail++;
      $display("unexpected bus timeout at %0t", $time);
    end
  endtask

  task key(input int k);
    @(posedge clk);
    keys <= 5'b1 << k;
    @(posedge clk);
    keys <= 5'h0;
  endtask

  task cmd_pulse(input logic rem, input fpi_pkg::fpi_brk_cmd_type c);
    @(posedge clk);
    if (rem) remote_cmd <= c;
    else comms_cmd <= c;
    repeat (3) @(posedge clk);
    remote_cmd <= 2'b00;
    comms_cmd <= 2'b00;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results;
  end

  initial begin
    {reset, cyc, stb, we, major_fail, minor_fail, trip_cond, pickup_cond} = 8'h80;
    {edit_active, conn, rcl_on, rcl_blk, rcl_dead, rcl_lock, local_in} = 7'h00;
    adr = 32'h0000_0000;
    wdat = 32'h0000_0000;
    {alarm_cond, alarm_lcfg, aux_req, aux_lcfg, keys} = 31'h0000_0000;
    {active_group, edit_group, remote_cmd, comms_cmd} = 8'h00;
    {racked_in, open_wired, sel} = 6'h3f;
    n_fail = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    wb(CTRL, 32'h0, 1'b0);
    chk(q, fpi_pkg::CTRL_RESET_VAL);
    wb(32'h0000_0010, 32'h0, 1'b0);
    chk(q, 32'h0);
    lamp_chk(L_INS, ON);
    minor_fail <= 1'b1;
    lamp_chk(L_INS, ON);
    lamp_chk(L_STW, ON);
    minor_fail <= 1'b0;
    major_fail <= 1'b1;
    trip_cond <= 1'b1;
    aux_req <= 5'h01;
    lamp_chk(L_INS, OFF);
    chk({trip_relay, aux_relay, st_relay}, 32'h0);
    chk(lv[L_STW], 1);
    {major_fail, trip_cond, aux_req} <= 7'h0;
    key(0);
    trip_cond <= 1'b1;
    alarm_cond <= 8'h01;
    lamp_chk(L_TRP, FL);
    chk(trip_relay, 1);
    repeat (10) begin
      @(posedge clk);
      chk(lv[L_TRP], lv[L_ALM]);
    end
    chk(disp_mode, 1);
    d0 = didx;
    key(1);
    repeat (2) @(posedge clk);
    chk(didx !== d0, 1);
    key(2);
    repeat (2) @(posedge clk);
    chk(disp_mode, 0);
    lamp_chk(L_MSG, FL);
    trip_cond <= 1'b0;
    alarm_cond <= 8'h0;
    lamp_chk(L_TRP, ON);
    lamp_chk(L_ALM, OFF);
    wb(fpi_pkg::WB_ADDR_DIAG, 32'h0, 1'b0);
    chk(q, 32'h0000_0100);
    trip_cond <= 1'b1;
    key(0);
    trip_cond <= 1'b0;
    lamp_chk(L_TRP, ON);
    wb(CTRL, 32'h0000_0102, 1'b1);
    lamp_chk(L_TRP, OFF);
    wb(fpi_pkg::WB_ADDR_DIAG, 32'h0, 1'b0);
    chk(q, 32'h0);
    {aux_lcfg, aux_req, alarm_lcfg, alarm_cond} <= 26'h21_0202;
    lamp_chk(L_ALM, FL);
    {aux_req, alarm_cond} <= 13'h0;
    lamp_chk(L_ALM, ON);
    chk(aux_relay, 1);
    key(0);
    lamp_chk(L_ALM, OFF);
    chk(aux_relay, 0);
    pickup_cond <= 1'b1;
    lamp_chk(L_PKP, ON);
    pickup_cond <= 1'b0;
    lamp_chk(L_PKP, OFF);
    wb(CTRL, 32'h0000_0101, 1'b1);
    lamp_chk(L_PKP, ON);
    alarm_cond <= 8'h01;
    lamp_chk(L_PKP, OFF);
    alarm_cond <= 8'h0;
    wb(CTRL, 32'h0000_0100, 1'b1);
    edit_active <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      active_group <= 2'(g);
      edit_group <= 2'(g + 1);
      lamp_chk(L_GRP + g, ON);
      lamp_chk(L_GRP + (g + 1) % 4, FL);
    end
    for (int i = 0; i < 4; i++) begin
      rcl_on <= i[0];
      rcl_blk <= i[1];
      lamp_chk(L_REN, (i == 1) ? ON : OFF);
      lamp_chk(L_RDI, (i == 1) ? OFF : ON);
    end
    rcl_dead <= 1'b1;
    lamp_chk(L_RIP, ON);
    rcl_dead <= 1'b0;
    lamp_chk(L_RIP, OFF);
    rcl_lock <= 1'b1;
    repeat (2) @(posedge clk);
    rcl_lock <= 1'b0;
    lamp_chk(L_RLO, ON);
    key(0);
    lamp_chk(L_RLO, OFF);
    lamp_chk(L_BOP, ON);
    cmd_pulse(1'b1, 2'b01);
    lamp_chk(L_BCL, ON);
    lamp_chk(L_BOP, OFF);
    local_in <= 1'b1;
    lamp_chk(L_LOC, ON);
    cmd_pulse(1'b1, 2'b10);
    cmd_pulse(1'b0, 2'b10);
    lamp_chk(L_BCL, ON);
    key(3);
    lamp_chk(L_BOP, ON);
    local_in <= 1'b0;
    key(4);
    lamp_chk(L_BOP, ON);
    cmd_pulse(1'b0, 2'b01);
    lamp_chk(L_BCL, ON);
    racked_in <= 1'b0;
    lamp_chk(L_BCL, OFF);
    lamp_chk(L_BOP, OFF);
    {racked_in, open_wired, conn} <= 3'b101;
    wb(CTRL, 32'h0000_0104, 1'b1);
    lamp_chk(L_BCL, ON);
    cmd_pulse(1'b0, 2'b10);
    lamp_chk(L_BOP, ON);
    // unwired open-sense contact stays open, so open-sense mode must show closed
    wb(CTRL, 32'h0000_010c, 1'b1);
    lamp_chk(L_BCL, ON);
    conn <= 1'b0;
    lamp_chk(L_BOP, OFF);
    lamp_chk(L_BCL, OFF);
    wb(CTRL, 32'h0000_1f00, 1'b1);
    wb(CTRL, 32'h0, 1'b0);
    chk(q[12:8], 31);
    // field keeps what was written; scrolling itself stops at 30 messages
    mx = 0;
    repeat (160) begin
      @(posedge clk);
      if (sidx > mx) mx = sidx;
    end
    chk(mx, 29);
    wb(CTRL, 32'h0000_0300, 1'b1);
    repeat (45) @(posedge clk);
    chk(disp_mode, 2);
    mx = 0;
    repeat (40) begin
      @(posedge clk);
      if (sidx > mx) mx = sidx;
    end
    chk(mx, 2);
    key(2);
    repeat (2) @(posedge clk);
    chk(disp_mode, 0);
    repeat (45) @(posedge clk);
    trip_cond <= 1'b1;
    repeat (4) @(posedge clk);
    chk(disp_mode, 1);
    results;
  end
endmodule
`default_nettype wire
